// ### rtl/mss_defines.vh
/*
 Constants for the microcode store sequencer: register offsets, field
 positions of the control buffer, reset values and timing counts.
 Assumes inclusion by its bare name from the sequencer design file.
*/
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSS_OFF_CTRL 12'h000
`define MSS_OFF_SECTOR 12'h004
`define MSS_OFF_DATA 12'h008
`define MSS_OFF_STATUS 12'h00C
`define MSS_OFF_PIR 12'h010

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define MSS_CTRL_OPTSEL 0
`define MSS_CTRL_INIT 1
`define MSS_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Microword field positions
// ----------------------------------------
`define MSS_F_T 17:16
`define MSS_F_S 19:18
`define MSS_F_IM 23:20
`define MSS_F_G 26:24
`define MSS_F_A 29:27
`define MSS_F_C 31:30
`define MSS_F_M 32
`define MSS_F_B0 33
`define MSS_F_RET 15:4

// ----------------------------------------
// Field codes
// ----------------------------------------
`define MSS_IM_NOMEM 4'h3
`define MSS_IM_SPECIAL 4'hD
`define MSS_S_MEMBR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSS_CLK_NS 8
`define MSS_FAST_NS 165
`define MSS_SLOW_NS 190
`define MSS_STRETCH_CYC (((`MSS_SLOW_NS - `MSS_FAST_NS) + `MSS_CLK_NS - 1) / `MSS_CLK_NS)

`endif

// ### rtl/mss_top.v
/*
 Sequencing and support logic of a writable microcode store board:
 sector access over APB, clock stretching, output buffer, control
 buffer, page-branch decoder, wide address mode, memory lockout,
 return stack and pseudo instruction register.
 Assumes all inputs synchronous to ref_clk at 125 MHz.
*/
// Overview of operation
// - Sector counter selects one 16-bit read sector
// - Sector counter decodes one of four write strobes
// - I/O data from sector or option multiplexor
// - Store fetch holds clock four extra ref_clk cycles, covering slow minus fast store time
// - Half clock plus request stretches phase three
// - Phase three plus page/strobe stretches phase four
// - Both enables low drive outputs, either one high floats them
// - Output to processor, stack, control buffer
// - Control buffer captures microword on clock trailing edge
// - Decode branch with memory control
// - Decode branch without memory control
// - Decode branch with push
// - Decode pop or pop with delete
// - Page branch asserts page select, processor line low
// - Wide mode flip-flop set and clear
// - Wide mode drives address bit 15 on port
// - Lockout request set and clear
// - Next acknowledge raises lockout output
// - Request clear or reset drops lockout at once
// - Sixteen word return stack, write or read
// - Stack pointer resets, increments, decrements
// - Pseudo IR loads on acknowledge trailing edge (memory_acknowledge_n rise) while load is low
// - Board reset from bus reset or initialize
`timescale 1ns/10ps
`include "mss_defines.vh"

module mss_top #(
    parameter STACK_DEPTH_LOG2 = 4,
    parameter RET_W = 12
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    input wire io_system_reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Sector access
    input wire [63:0] store_word,
    input wire [15:0] option_input,
    output reg [3:0] sector_write_strobe,
    output reg [15:0] sector_write_data,
    output reg [15:0] io_bus_data,
    // Clock control
    input wire store_fetch,
    input wire half_clock_phase,
    input wire phase_three_timing,
    input wire store_address_select_n,
    input wire decoder_enable_request_n,
    input wire branch_strobe_decoded_n,
    output reg clock_hold,
    output reg phase3_extend,
    output reg phase4_extend,
    // Output buffer and control buffer
    input wire low_byte_output_enable_n,
    input wire high_bits_output_enable_n,
    input wire [63:0] microword_bus_in,
    input wire full_clock_received_n,
    output reg [63:0] microword_output_bus,
    output wire microword_low_oe,
    output wire microword_high_oe,
    // Page-branch decoder
    output wire memory_branch_decoded_n,
    output wire push_branch_decoded_n,
    output wire pop_branch_decoded_n,
    output wire delete_branch_decoded_n,
    output wire page_select_active_n,
    output wire page_branch_to_processor_n,
    // Memory ports
    input wire port_b_selected,
    input wire port_a_acknowledge,
    input wire port_b_acknowledge,
    output wire port_a_addr15,
    output wire port_a_addr15_oe,
    output wire port_b_addr15,
    output wire port_b_addr15_oe,
    output wire wide_address_mode,
    output wire lockout_request,
    output wire lockout_active,
    // Return stack
    output wire [STACK_DEPTH_LOG2-1:0] stack_pointer_bits,
    output wire stack_write_enable_n,
    output reg [RET_W-1:0] stack_return_address,
    // Pseudo instruction register
    input wire [15:0] mem_data_a,
    input wire [15:0] mem_data_b,
    input wire pseudo_ir_load_n,
    input wire memory_acknowledge_n,
    output wire [8:0] processor_store_address,
    // Reset out
    output wire board_system_reset_n
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [15:0] sector_pick;
        input [63:0] w;
        input [1:0] s;
        begin
            case (s)
                2'h0: sector_pick = w[15:0];
                2'h1: sector_pick = w[31:16];
                2'h2: sector_pick = w[47:32];
                default: sector_pick = w[63:48];
            endcase
        end
    endfunction
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam DEPTH = 1 << STACK_DEPTH_LOG2;
    localparam integer HOLD_CYC = `MSS_STRETCH_CYC;
    reg [31:0] ctrl_r;
    reg init_r;
    reg [1:0] sector_count_r;
    reg [63:0] cbuf_r;
    reg [RET_W-1:0] stk_buf_r;
    reg cap_r;
    reg fclk_n_prev_r;
    reg wide_r;
    reg lock_req_r;
    reg lock_act_r;
    reg ack_a_prev_r;
    reg ack_b_prev_r;
    reg mack_n_prev_r;
    reg [15:0] pir_r;
    reg [STACK_DEPTH_LOG2-1:0] sp_r;
    reg [RET_W-1:0] stack_mem [0:DEPTH-1];
    reg [3:0] hold_cnt_r;
    reg push_r;
    reg [31:0] rd_nxt;
    integer i;
    wire sys_rst;
    wire wr_en;
    wire rd_en;
    wire drive_all;
    wire [63:0] word_seen;
    wire fclk_trail;
    wire base_st;
    wire special;
    wire mem_br;
    wire push_br;
    wire pop_br;
    wire del_br;
    wire page_sel;
    wire ack_rise;
    wire [15:0] io_sel;
    wire [STACK_DEPTH_LOG2-1:0] sp_up;
    // ----------------------------------------
    // Reset and APB
    // ----------------------------------------
    assign sys_rst = rst | io_system_reset | init_r;
    assign board_system_reset_n = ~sys_rst;
    assign wr_en = psel & penable & pwrite;
    // Read data loaded at setup so it already stands at the access edge
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr > `MSS_OFF_PIR);
    // Sector read word; option path lets software read strap data
    assign io_sel = ctrl_r[`MSS_CTRL_OPTSEL] ? option_input :
                    sector_pick(store_word, sector_count_r);
    always @* begin
        case (paddr)
            `MSS_OFF_CTRL: rd_nxt = ctrl_r;
            `MSS_OFF_SECTOR: rd_nxt = {30'h0000_0000, sector_count_r};
            `MSS_OFF_DATA: rd_nxt = {16'h0000, io_sel};
            `MSS_OFF_STATUS: rd_nxt = {24'h00_0000, sp_r, 1'b0, lockout_active, lock_req_r, wide_r};
            `MSS_OFF_PIR: rd_nxt = {16'h0000, pir_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= `MSS_CTRL_RESET;
            init_r <= 1'b0;
            sector_count_r <= 2'h0;
            sector_write_strobe <= 4'h0;
            sector_write_data <= 16'h0000;
            prdata <= 32'h0000_0000;
            io_bus_data <= 16'h0000;
        end else begin
            init_r <= wr_en && paddr == `MSS_OFF_CTRL && pwdata[`MSS_CTRL_INIT];
            sector_write_strobe <= 4'h0;
            io_bus_data <= io_sel;
            if (rd_en) begin
                prdata <= rd_nxt;
            end
            if (wr_en && paddr == `MSS_OFF_CTRL) begin
                ctrl_r <= {31'h0000_0000, pwdata[`MSS_CTRL_OPTSEL]};
            end
            if (wr_en && paddr == `MSS_OFF_SECTOR) begin
                sector_count_r <= pwdata[1:0];
            end
            if (wr_en && paddr == `MSS_OFF_DATA) begin
                sector_write_strobe <= 4'h1 << sector_count_r;
                sector_write_data <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // Clock control
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hold_cnt_r <= 4'h0;
            clock_hold <= 1'b0;
            phase3_extend <= 1'b0;
            phase4_extend <= 1'b0;
        end else begin
            if (store_fetch && hold_cnt_r == 4'h0) begin
                hold_cnt_r <= HOLD_CYC[3:0];
                clock_hold <= 1'b1;
            end else if (hold_cnt_r > 4'h1) begin
                hold_cnt_r <= hold_cnt_r - 4'h1;
            end else begin
                hold_cnt_r <= 4'h0;
                clock_hold <= 1'b0;
            end
            phase3_extend <= half_clock_phase & (~store_address_select_n | ~decoder_enable_request_n);
            phase4_extend <= phase_three_timing & (page_sel | ~branch_strobe_decoded_n);
        end
    end
    // ----------------------------------------
    // Output buffer and control buffer
    // ----------------------------------------
    // Both enables move together on the board; a split pair drives nothing
    assign drive_all = ~low_byte_output_enable_n & ~high_bits_output_enable_n;
    assign microword_low_oe = drive_all;
    assign microword_high_oe = drive_all;
    assign word_seen = drive_all ? microword_output_bus : microword_bus_in;
    assign fclk_trail = ~fclk_n_prev_r & full_clock_received_n;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            microword_output_bus <= 64'h0000_0000_0000_0000;
            cbuf_r <= 64'h0000_0000_0000_0000;
            stk_buf_r <= {RET_W{1'b0}};
            cap_r <= 1'b0;
            fclk_n_prev_r <= 1'b1;
        end else begin
            microword_output_bus <= store_word;
            fclk_n_prev_r <= full_clock_received_n;
            cap_r <= fclk_trail;
            if (fclk_trail) begin
                cbuf_r <= {word_seen[63:16], 12'h000, word_seen[3:0]};
                stk_buf_r <= word_seen[`MSS_F_RET];
            end
        end
    end
    // ----------------------------------------
    // Page-branch decoder
    // ----------------------------------------
    assign base_st = cbuf_r[`MSS_F_T] == 2'h0 && cbuf_r[`MSS_F_S] == 2'h0;
    assign special = base_st && cbuf_r[`MSS_F_IM] == `MSS_IM_SPECIAL;
    assign mem_br = (cbuf_r[`MSS_F_T] == 2'h0 && cbuf_r[`MSS_F_S] == `MSS_S_MEMBR && cbuf_r[26])
                  | (base_st && cbuf_r[`MSS_F_IM] == `MSS_IM_NOMEM);
    assign push_br = special & cbuf_r[28];
    assign pop_br = special & cbuf_r[29] & cbuf_r[`MSS_F_B0];
    assign del_br = special & cbuf_r[29] & ~cbuf_r[`MSS_F_B0];
    assign page_sel = mem_br | push_br | pop_br | del_br;
    assign memory_branch_decoded_n = ~mem_br;
    assign push_branch_decoded_n = ~push_br;
    assign pop_branch_decoded_n = ~pop_br;
    assign delete_branch_decoded_n = ~del_br;
    assign page_select_active_n = ~page_sel;
    assign page_branch_to_processor_n = ~page_sel;

    // ----------------------------------------
    // Wide address mode and lockout
    // ----------------------------------------
    assign ack_rise = (port_a_acknowledge & ~ack_a_prev_r) | (port_b_acknowledge & ~ack_b_prev_r);
    assign wide_address_mode = wide_r;
    assign port_a_addr15 = wide_r;
    assign port_a_addr15_oe = wide_r & ~port_b_selected;
    assign port_b_addr15 = wide_r;
    assign port_b_addr15_oe = wide_r & port_b_selected;
    assign lockout_request = lock_req_r;
    // Gated by the request so a clear drops it in the same cycle
    assign lockout_active = lock_act_r & lock_req_r;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wide_r <= 1'b0;
            lock_req_r <= 1'b0;
            lock_act_r <= 1'b0;
            ack_a_prev_r <= 1'b0;
            ack_b_prev_r <= 1'b0;
        end else begin
            ack_a_prev_r <= port_a_acknowledge;
            ack_b_prev_r <= port_b_acknowledge;
            if (cap_r && special && cbuf_r[`MSS_F_M]) begin
                wide_r <= 1'b1;
            end else if (cap_r && special && cbuf_r[31]) begin
                wide_r <= 1'b0;
            end
            if (cap_r && special && cbuf_r[30]) begin
                lock_req_r <= 1'b1;
            end else if (cap_r && special && cbuf_r[27]) begin
                lock_req_r <= 1'b0;
            end
            if (!lock_req_r) begin
                lock_act_r <= 1'b0;
            end else if (ack_rise) begin
                lock_act_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Return stack
    // ----------------------------------------
    assign sp_up = sp_r + 1'b1;
    assign stack_pointer_bits = sp_r;
    assign stack_write_enable_n = ~push_r;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sp_r <= {STACK_DEPTH_LOG2{1'b0}};
            push_r <= 1'b0;
            stack_return_address <= {RET_W{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                stack_mem[i] <= {RET_W{1'b0}};
            end
        end else begin
            push_r <= cap_r & push_br;
            stack_return_address <= stack_mem[sp_r];
            if (cap_r && push_br) begin
                stack_mem[sp_up] <= stk_buf_r;
                sp_r <= sp_up;
            end else if (cap_r && (pop_br || del_br)) begin
                sp_r <= sp_r - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Pseudo instruction register
    // ----------------------------------------
    assign processor_store_address = pir_r[8:0];
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pir_r <= 16'h0000;
            mack_n_prev_r <= 1'b1;
        end else begin
            mack_n_prev_r <= memory_acknowledge_n;
            if (!mack_n_prev_r && memory_acknowledge_n && !pseudo_ir_load_n) begin
                pir_r <= port_b_selected ? mem_data_b : mem_data_a;
            end
        end
    end

endmodule

// ### tb/mss_props.sv
/* Port assertions for the microcode store sequencer.
   Assumes bind into mss_top, ref_clk domain, sync reset rst. */
`timescale 1ns/10ps
module mss_props #(
    parameter STACK_DEPTH_LOG2 = 4
) (
    // Clock, reset, bus
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    // Sector and timing
    input wire [3:0] sector_write_strobe,
    input wire clock_hold,
    // Buffer and decoder
    input wire low_byte_output_enable_n,
    input wire high_bits_output_enable_n,
    input wire microword_low_oe,
    input wire microword_high_oe,
    input wire memory_branch_decoded_n,
    input wire push_branch_decoded_n,
    input wire pop_branch_decoded_n,
    input wire delete_branch_decoded_n,
    input wire page_select_active_n,
    input wire page_branch_to_processor_n,
    // Ports, modes, stack
    input wire port_b_selected,
    input wire port_a_acknowledge,
    input wire port_b_acknowledge,
    input wire port_a_addr15_oe,
    input wire wide_address_mode,
    input wire lockout_request,
    input wire lockout_active,
    input wire [STACK_DEPTH_LOG2-1:0] stack_pointer_bits,
    input wire stack_write_enable_n
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
// ----------------
// Sequences
// ----------------
sequence data_write;
    $past(psel && penable && pwrite && paddr == 12'h008);
endsequence
sequence hold_run;
    clock_hold [*4] ##1 !clock_hold;
endsequence
sequence ack_rise;
    $rose(port_a_acknowledge) || $rose(port_b_acknowledge);
endsequence
// ----------------
// Properties
// ----------------
a_strobe_one_pulse: assert property (|sector_write_strobe |->
    $onehot(sector_write_strobe) ##0 data_write ##1 sector_write_strobe == 4'h0) else $error("strobe fault");
a_hold_four: assert property ($rose(clock_hold) |-> hold_run) else $error("hold length");
a_oe_both_low: assert property (microword_low_oe == microword_high_oe &&
    microword_low_oe == (!low_byte_output_enable_n && !high_bits_output_enable_n)) else $error("oe fault");
a_page_any: assert property (page_select_active_n == (memory_branch_decoded_n &
    push_branch_decoded_n & pop_branch_decoded_n & delete_branch_decoded_n)) else $error("page select");
a_page_proc: assert property (page_branch_to_processor_n == page_select_active_n) else $error("page line");
a_addr15_port: assert property (port_a_addr15_oe == (wide_address_mode && !port_b_selected))
    else $error("addr15 port");
a_lock_on_ack: assert property (lockout_request ##0 ack_rise |-> ##[1:2] (lockout_active || !lockout_request))
    else $error("lock late");
a_lock_holds: assert property (lockout_active |=> lockout_active || !lockout_request) else $error("lock lost");
a_lock_needs_req: assert property (lockout_active |-> lockout_request) else $error("lock stuck");
a_sp_step: assert property ($changed(stack_pointer_bits) |-> stack_pointer_bits == '0 ||
    stack_pointer_bits == $past(stack_pointer_bits) + 1'b1 ||
    stack_pointer_bits == $past(stack_pointer_bits) - 1'b1) else $error("sp jump");
a_push_pulse: assert property (!stack_write_enable_n |=> stack_write_enable_n) else $error("push long");
endmodule
bind mss_top mss_props #(.STACK_DEPTH_LOG2(STACK_DEPTH_LOG2)) u_mss_props (.*);

// ### tb/mss_proc_model.sv
/* Processor side: control store word, full clock, acknowledges
   and memory data. Assumes tasks called from the bench. */
`timescale 1ns/10ps
module mss_proc_model (
    // Clock
    input wire ref_clk,
    // Control store side
    output logic [63:0] store_word,
    output logic [63:0] microword_bus_in,
    output logic full_clock_received_n,
    // Memory ports
    output logic port_a_acknowledge,
    output logic port_b_acknowledge,
    output logic [15:0] mem_data_a,
    output logic [15:0] mem_data_b,
    output logic pseudo_ir_load_n,
    output logic memory_acknowledge_n
);
initial begin
    store_word = 64'h0;
    microword_bus_in = 64'hFFFF_FFFF_FFFF_FFFF;
    {full_clock_received_n, pseudo_ir_load_n, memory_acknowledge_n} = 3'h7;
    {port_a_acknowledge, port_b_acknowledge} = 2'h0;
    {mem_data_a, mem_data_b} = 32'hFFFF_0000;
end
// ----------------
// Full clock with a new microword
// ----------------
task issue(input [63:0] w);
    @(posedge ref_clk);
    store_word <= w;
    microword_bus_in <= ~w; // Floated bus never echoes the word
    full_clock_received_n <= 1'b0;
    @(posedge ref_clk);
    full_clock_received_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
endtask
task ack(input b);
    @(posedge ref_clk);
    if (b) port_b_acknowledge <= 1'b1; else port_a_acknowledge <= 1'b1;
    @(posedge ref_clk);
    {port_a_acknowledge, port_b_acknowledge} <= 2'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
endtask
task pir(input [15:0] a, input [15:0] b, input ld_n);
    @(posedge ref_clk);
    {mem_data_a, mem_data_b, pseudo_ir_load_n} <= {a, b, ld_n};
    memory_acknowledge_n <= 1'b0;
    @(posedge ref_clk);
    memory_acknowledge_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    {mem_data_a, mem_data_b, pseudo_ir_load_n} <= {~a, ~b, 1'b1}; // Data gone after hold
    @(negedge ref_clk);
endtask
endmodule

// ### tb/testbench.sv
/* Self-checking bench for the microcode store sequencer.
   Assumes mss_top, the processor model and the bound checker. */
`timescale 1ns/10ps
module testbench;
localparam [63:0] WRD = 64'hFEDC_BA98_7654_3210;
reg ref_clk = 0, rst = 1, io_system_reset = 0, psel = 0, penable = 0, pwrite = 0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, r;
reg [15:0] option_input = 16'hC3A5;
reg store_fetch = 0, half_clock_phase = 0, phase_three_timing = 0, e;
reg store_address_select_n = 1, decoder_enable_request_n = 1, branch_strobe_decoded_n = 1;
reg low_byte_output_enable_n = 0, high_bits_output_enable_n = 0, port_b_selected = 0;
reg [3:0] seen = 4'h0;
wire [63:0] store_word, microword_bus_in, microword_output_bus;
wire [31:0] prdata;
wire [15:0] mem_data_a, mem_data_b, sector_write_data, io_bus_data;
wire [11:0] stack_return_address;
wire [8:0] processor_store_address;
wire [3:0] sector_write_strobe, stack_pointer_bits;
wire pready, pslverr, clock_hold, phase3_extend, phase4_extend, microword_low_oe, microword_high_oe;
wire memory_branch_decoded_n, push_branch_decoded_n, pop_branch_decoded_n, delete_branch_decoded_n;
wire page_select_active_n, page_branch_to_processor_n, port_a_acknowledge, port_b_acknowledge;
wire port_a_addr15, port_a_addr15_oe, port_b_addr15, port_b_addr15_oe, wide_address_mode;
wire lockout_request, lockout_active, stack_write_enable_n, pseudo_ir_load_n;
wire memory_acknowledge_n, full_clock_received_n, board_system_reset_n;
integer num_errors = 0, compares = 0, i, n;
mss_top u_mss_top (.*);
mss_proc_model u_mss_proc_model (.*);
initial forever #4 ref_clk = ~ref_clk;
always @(posedge ref_clk) if (|sector_write_strobe) seen <= sector_write_strobe;
// ----------------
// Shared tasks
// ----------------
task chk(input string nm, input [63:0] x, input [63:0] g);
    compares++;
    if (g !== x) begin
        num_errors++;
        $display("Error %s expected %h seen %h", nm, x, g);
    end
endtask
task tk(input integer c);
    repeat (c) @(posedge ref_clk);
    @(negedge ref_clk);
endtask
task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
        @(posedge ref_clk);
    end while (pready !== 1'b1);
    e = pslverr;
    r = prdata; // Taken at the pready edge
    {psel, penable} <= 2'h0;
    tk(1);
endtask
function [63:0] mw(input [1:0] s, input [3:0] im, input [2:0] g, a, input [1:0] c, input m, b);
    mw = {30'h0, b, m, c, a, g, im, s, 18'h0};
endfunction
task dec(input [63:0] w, input [5:0] x);
    u_mss_proc_model.issue(w);
    chk("decode", x, {memory_branch_decoded_n, push_branch_decoded_n, pop_branch_decoded_n,
        delete_branch_decoded_n, page_select_active_n, page_branch_to_processor_n});
endtask
task report_and_stop;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
// ----------------
// Scenarios
// ----------------
task t_sector;
    u_mss_proc_model.issue(WRD);
    for (i = 0; i < 4; i++) begin
        apb(12'h004, 1, i);
        seen = 4'h0;
        apb(12'h008, 1, 32'h5A00 + i);
        chk("strobe", 4'h1 << i, seen);
        chk("wdata", 16'h5A00 + i, sector_write_data);
        apb(12'h008, 0, 0);
        chk("sector", WRD[16*i +: 16], r[15:0]);
        chk("iobus", WRD[16*i +: 16], io_bus_data);
    end
    apb(12'h000, 1, 1);
    apb(12'h008, 0, 0);
    chk("option", option_input, r[15:0]);
    chk("opt bus", option_input, io_bus_data);
    apb(12'h000, 1, 0);
    apb(12'h014, 0, 0);
    chk("slverr", 2'h2, {e, |r});
endtask
task t_decode;
    dec(mw(2, 0, 4, 0, 0, 0, 0), 6'h1C);
    dec(mw(2, 0, 3, 0, 0, 0, 0), 6'h3F);
    dec(mw(0, 3, 0, 0, 0, 0, 0), 6'h1C);
    dec(mw(0, 13, 0, 2, 0, 0, 0), 6'h2C);
    dec(mw(0, 13, 0, 4, 0, 0, 1), 6'h34);
    dec(mw(0, 13, 0, 4, 0, 0, 0), 6'h38);
endtask
task t_modes;
    u_mss_proc_model.issue(mw(0, 13, 0, 0, 0, 1, 0));
    chk("wide a", 3'h7, {wide_address_mode, port_a_addr15, port_a_addr15_oe});
    @(posedge ref_clk) port_b_selected <= 1'b1;
    tk(1);
    chk("wide b", 3'h6, {port_b_addr15, port_b_addr15_oe, port_a_addr15_oe});
    u_mss_proc_model.issue(mw(0, 13, 0, 0, 2, 0, 0));
    chk("wide off", 0, wide_address_mode);
    u_mss_proc_model.issue(mw(0, 13, 0, 0, 1, 0, 0));
    chk("lock req", 2'h2, {lockout_request, lockout_active});
    u_mss_proc_model.ack(1);
    chk("lock on", 2'h3, {lockout_request, lockout_active});
    u_mss_proc_model.issue(mw(0, 13, 0, 1, 0, 0, 0));
    chk("lock off", 2'h0, {lockout_request, lockout_active});
endtask
task t_stack;
    @(posedge ref_clk) io_system_reset <= 1'b1;
    tk(1);
    chk("board rst", 0, board_system_reset_n);
    @(posedge ref_clk) io_system_reset <= 1'b0;
    tk(1);
    chk("sp rst", 0, stack_pointer_bits);
    for (i = 0; i < 16; i++) begin
        u_mss_proc_model.issue(mw(0, 13, 0, 2, 0, 0, 0) | (i << 4));
        chk("sp push", (i + 1) % 16, stack_pointer_bits);
    end
    chk("top", 12'hF, stack_return_address);
    u_mss_proc_model.issue(mw(0, 13, 0, 4, 0, 0, 1));
    chk("sp pop", 4'hF, stack_pointer_bits);
    chk("ret", 12'hE, stack_return_address);
    apb(12'h000, 1, 32'h2);
    chk("init sp", 0, stack_pointer_bits);
endtask
task t_timing;
    @(posedge ref_clk) store_fetch <= 1'b1;
    @(posedge ref_clk) store_fetch <= 1'b0;
    n = 0;
    for (i = 0; i < 10; i++) @(negedge ref_clk) n += clock_hold;
    chk("hold", 4, n);
    @(posedge ref_clk) {half_clock_phase, store_address_select_n} <= 2'h2;
    tk(2);
    chk("p3 sel", 1, phase3_extend);
    @(posedge ref_clk) {store_address_select_n, decoder_enable_request_n} <= 2'h2;
    tk(2);
    chk("p3 dec", 1, phase3_extend);
    @(posedge ref_clk) {half_clock_phase, phase_three_timing, branch_strobe_decoded_n} <= 3'h2;
    tk(2);
    chk("p3 p4", 2'h1, {phase3_extend, phase4_extend});
    @(posedge ref_clk) {phase_three_timing, decoder_enable_request_n, branch_strobe_decoded_n} <= 3'h3;
    tk(2);
    chk("p4 off", 0, phase4_extend);
    u_mss_proc_model.issue(mw(0, 3, 0, 0, 0, 0, 0));
    @(posedge ref_clk) phase_three_timing <= 1'b1;
    tk(2);
    chk("p4 page", 1, phase4_extend);
endtask
task t_buf_pir;
    u_mss_proc_model.issue(WRD);
    chk("obus", WRD, microword_output_bus);
    chk("oe on", 2'h3, {microword_low_oe, microword_high_oe});
    @(posedge ref_clk) {low_byte_output_enable_n, high_bits_output_enable_n} <= 2'h3;
    tk(1);
    chk("float", 2'h0, {microword_low_oe, microword_high_oe});
    u_mss_proc_model.pir(16'h02AA, 16'h0177, 0);
    chk("pir b", 9'h177, processor_store_address);
    @(posedge ref_clk) port_b_selected <= 1'b0;
    u_mss_proc_model.pir(16'h0123, 16'h0155, 0);
    chk("pir a", 9'h123, processor_store_address);
    u_mss_proc_model.pir(16'h0000, 16'h0000, 1);
    chk("pir hold", 9'h123, processor_store_address);
endtask
initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_sector;
    t_decode;
    t_modes;
    t_stack;
    t_timing;
    t_buf_pir;
    report_and_stop;
end
initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop;
end
endmodule
